//--- ppc_top.v
// register bank and global logic of the four-port power-sourcing controller
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.vh"

module ppc_top #(
  parameter [19:0] CUT_CYCLES = `PPC_CUT_CYCLES
) (
  input wire CLK,
  input wire RST,
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  input wire OVERTEMP,
  input wire VEE_UVLO,
  input wire [15:0] VEE_MV,
  input wire [63:0] PORT_CURRENT,
  input wire [3:0] DET_GOOD,
  input wire [3:0] CLASS_VALID,
  input wire [11:0] CLASS_RESULT,
  input wire [3:0] DISCONNECT,
  output wire [3:0] PORT_POWER,
  output wire [3:0] DET_ENABLE,
  output wire [3:0] CLASS_REQ,
  output wire [3:0] MARK_REQ,
  output wire [3:0] CLASS_ERR,
  output wire [3:0] LIMIT_HIGH,
  output wire DET_BACKOFF,
  output wire INT_N
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0] cfg_reg [0:3];
  reg [7:0] cut_reg [0:3];
  reg [15:0] meas_reg [0:4];
  reg overtemp_reg;
  reg uvlo_reg;
  reg backoff_reg;
  reg int_ot_reg;
  reg int_uv_reg;
  reg chip_rst_reg;
  reg [3:0] man_on_reg;
  reg [3:0] man_off_reg;
  reg [3:0] port_rst_reg;

  wire dev_rst;
  wire [7:0] cfg_off;
  wire [7:0] cut_off;
  wire [7:0] ret_off;
  wire hit_cfg;
  wire hit_cut;
  wire hit_ret;
  wire cmd_wr;
  wire [2:0] cmd_code;
  wire [1:0] cmd_param;
  wire [7:0] int_value;
  wire [7:0] stat_value;
  wire [3:0] trip;
  wire [3:0] cut_load;
  wire [11:0] class_first;
  wire [15:0] ret_word;
  reg [7:0] rd_mux;
  integer i;
  integer k;

  // undervoltage holds the port and configuration logic in reset, while the
  // status and interrupt flops keep running so the change is still reported
  assign dev_rst = RST | chip_rst_reg | uvlo_reg;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign cfg_off = REG_ADDR - `PPC_OFS_CFG;
  assign cut_off = REG_ADDR - `PPC_OFS_CUT;
  assign ret_off = REG_ADDR - `PPC_OFS_RET;
  assign hit_cfg = REG_ADDR >= `PPC_OFS_CFG && REG_ADDR < `PPC_OFS_CUT;
  assign hit_cut = REG_ADDR >= `PPC_OFS_CUT && REG_ADDR < `PPC_OFS_CMD;
  assign hit_ret = REG_ADDR >= `PPC_OFS_RET && REG_ADDR <= `PPC_OFS_RET_LAST;
  assign cmd_wr = REG_WR && REG_ADDR == `PPC_OFS_CMD;
  assign cmd_code = REG_WDATA[`PPC_CMD_CODE_HI:`PPC_CMD_CODE_LO];
  assign cmd_param = REG_WDATA[`PPC_CMD_PARAM_HI:`PPC_CMD_PARAM_LO];

  // ----------------------------------------------------------------
  // automatic threshold by class and high-power bit
  // ----------------------------------------------------------------
  function [7:0] auto_cut;
    input [2:0] cls;
    input high;
    begin
      case (cls)
        3'h1: auto_cut = `PPC_CUT_CLASS1;
        3'h2: auto_cut = `PPC_CUT_CLASS2;
        3'h4: auto_cut = high ? `PPC_CUT_HIGH : `PPC_CUT_RESET;
        default: auto_cut = `PPC_CUT_RESET;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // configuration and threshold registers
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (dev_rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        cfg_reg[i] <= `PPC_CFG_RESET;
        cut_reg[i] <= `PPC_CUT_RESET;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        // a host write wins over the automatic load in the same cycle
        if (REG_WR && hit_cut && cut_off[1:0] == i[1:0]) begin
          cut_reg[i] <= REG_WDATA;
        end else if (cut_load[i]) begin
          cut_reg[i] <= auto_cut(class_first[3*i +: 3],
                                 cfg_reg[i][`PPC_CFG_HIGH_POWER]);
        end
      end
      if (REG_WR && hit_cfg) begin
        cfg_reg[cfg_off[1:0]] <= {4'h0, REG_WDATA[3:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // command register: decoded into one-cycle strobes, except back-off, which toggles a held bit
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      chip_rst_reg <= 1'b0;
    end else begin
      chip_rst_reg <= cmd_wr && cmd_code == `PPC_CMD_CHIP_RESET;
    end
  end

  always @(posedge CLK) begin
    if (dev_rst) begin
      man_on_reg <= 4'h0;
      man_off_reg <= 4'h0;
      port_rst_reg <= 4'h0;
      backoff_reg <= 1'b0;
    end else begin
      man_on_reg <= 4'h0;
      man_off_reg <= 4'h0;
      port_rst_reg <= 4'h0;
      if (cmd_wr) begin
        case (cmd_code)
          `PPC_CMD_PORT_ON: man_on_reg[cmd_param] <= 1'b1;
          `PPC_CMD_PORT_OFF: man_off_reg[cmd_param] <= 1'b1;
          `PPC_CMD_PORT_RESET: port_rst_reg[cmd_param] <= 1'b1;
          `PPC_CMD_BACKOFF: begin
            if (cmd_param == 2'h0) begin
              backoff_reg <= ~backoff_reg;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // measurement return registers
  // ----------------------------------------------------------------
  // only a measurement command loads them; a later port shutdown keeps the value
  always @(posedge CLK) begin
    if (dev_rst) begin
      for (k = 0; k < 5; k = k + 1) begin
        meas_reg[k] <= 16'h0000;
      end
    end else if (cmd_wr) begin
      if (cmd_code == `PPC_CMD_MEAS_CURRENT) begin
        meas_reg[{1'b0, cmd_param}] <= PORT_POWER[cmd_param] ?
          PORT_CURRENT[16*cmd_param +: 16] : 16'h0000;
      end else if (cmd_code == `PPC_CMD_MEAS_VEE) begin
        meas_reg[`PPC_VEE_SLOT] <= VEE_MV;
      end
    end
  end

  // ----------------------------------------------------------------
  // device status and interrupt
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      overtemp_reg <= 1'b0;
      uvlo_reg <= 1'b0;
      int_ot_reg <= 1'b0;
      int_uv_reg <= 1'b0;
    end else begin
      overtemp_reg <= OVERTEMP;
      uvlo_reg <= VEE_UVLO;
      // a change in the cycle of the clearing read still sets the bit
      if (overtemp_reg != OVERTEMP) begin
        int_ot_reg <= 1'b1;
      end else if (REG_RD && REG_ADDR == `PPC_OFS_STAT) begin
        int_ot_reg <= 1'b0;
      end
      if (uvlo_reg != VEE_UVLO) begin
        int_uv_reg <= 1'b1;
      end else if (REG_RD && REG_ADDR == `PPC_OFS_STAT) begin
        int_uv_reg <= 1'b0;
      end
    end
  end

  assign int_value = {1'b0, int_ot_reg, int_uv_reg, 5'h00};
  assign stat_value = {1'b0, overtemp_reg, uvlo_reg, 4'h0, backoff_reg};
  assign INT_N = ~(|int_value);
  assign DET_BACKOFF = backoff_reg;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  assign ret_word = meas_reg[ret_off[3:1]];

  always @* begin
    rd_mux = 8'h00;
    if (REG_ADDR == `PPC_OFS_INT) begin
      rd_mux = int_value;
    end else if (hit_cfg) begin
      rd_mux = cfg_reg[cfg_off[1:0]];
    end else if (hit_cut) begin
      rd_mux = cut_reg[cut_off[1:0]];
    end else if (hit_ret) begin
      rd_mux = ret_off[0] ? ret_word[15:8] : ret_word[7:0];
    end else if (REG_ADDR == `PPC_OFS_STAT) begin
      rd_mux = stat_value;
    end
    // the command register and unmapped offsets fall through to zero
  end

  always @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // per-port sequencers and overload timers
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_port
      // limit is a static select; the analog side picks 850 or 425 mA from it
      assign LIMIT_HIGH[p] = cfg_reg[p][`PPC_CFG_HIGH_POWER];

      ppc_port u_port (
        .clk(CLK),
        .rst(dev_rst),
        .mode(cfg_reg[p][`PPC_CFG_MODE_HI:`PPC_CFG_MODE_LO]),
        .disc_en(cfg_reg[p][`PPC_CFG_DISC_EN]),
        .det_good(DET_GOOD[p]),
        .class_valid(CLASS_VALID[p]),
        .class_result(CLASS_RESULT[3*p +: 3]),
        .disconnect(DISCONNECT[p]),
        .trip(trip[p]),
        .man_on(man_on_reg[p]),
        .man_off(man_off_reg[p]),
        .port_rst(port_rst_reg[p]),
        .power(PORT_POWER[p]),
        .det_en(DET_ENABLE[p]),
        .class_req(CLASS_REQ[p]),
        .mark_req(MARK_REQ[p]),
        .class_err(CLASS_ERR[p]),
        .cut_load(cut_load[p]),
        .class_first(class_first[3*p +: 3])
      );

      ppc_cut_timer #(
        .CUT_CYCLES(CUT_CYCLES)
      ) u_cut (
        .clk(CLK),
        .rst(dev_rst),
        .powered(PORT_POWER[p]),
        .current(PORT_CURRENT[16*p +: 16]),
        .cut(cut_reg[p]),
        .trip(trip[p])
      );
    end
  endgenerate

endmodule // ppc_top

`default_nettype wire

//--- ppc_map.vh
// register offsets, field positions, reset values and timing constants of the port controller
`ifndef PPC_MAP_VH
`define PPC_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PPC_OFS_INT 8'h00
`define PPC_OFS_CFG 8'h0A
`define PPC_OFS_CUT 8'h0E
`define PPC_OFS_CMD 8'h12
`define PPC_OFS_RET 8'h13
`define PPC_OFS_RET_LAST 8'h1C
`define PPC_OFS_STAT 8'h1D

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PPC_CFG_MODE_LO 0
`define PPC_CFG_MODE_HI 1
`define PPC_CFG_DISC_EN 2
`define PPC_CFG_HIGH_POWER 3
`define PPC_STAT_OVERTEMP 6
`define PPC_STAT_UVLO 5
`define PPC_STAT_BACKOFF 0
`define PPC_INT_OVERTEMP 6
`define PPC_INT_UVLO 5
`define PPC_CMD_PARAM_LO 0
`define PPC_CMD_PARAM_HI 1
`define PPC_CMD_CODE_LO 2
`define PPC_CMD_CODE_HI 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PPC_CFG_RESET 8'h04
`define PPC_CUT_RESET 8'h75

// ----------------------------------------------------------------
// port modes
// ----------------------------------------------------------------
`define PPC_MODE_SHUTDOWN 2'h0
`define PPC_MODE_MANUAL 2'h1
`define PPC_MODE_SEMIAUTO 2'h2
`define PPC_MODE_AUTO 2'h3

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define PPC_CMD_PORT_ON 3'h0
`define PPC_CMD_PORT_OFF 3'h1
`define PPC_CMD_PORT_RESET 3'h2
`define PPC_CMD_CHIP_RESET 3'h3
`define PPC_CMD_BACKOFF 3'h4
`define PPC_CMD_MEAS_CURRENT 3'h5
`define PPC_CMD_MEAS_VEE 3'h6

// ----------------------------------------------------------------
// classification results, automatic thresholds and the VEE return slot
// ----------------------------------------------------------------
`define PPC_CLASS_4 3'h4
`define PPC_CLASS_OVL 3'h6
`define PPC_CUT_CLASS1 8'h1F
`define PPC_CUT_CLASS2 8'h3A
`define PPC_CUT_HIGH 8'hC0
`define PPC_VEE_SLOT 3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PPC_CLK_KHZ 10000
`define PPC_T_CUT_MS 60
// 60 ms of overload at the 10 MHz clock
`define PPC_CUT_CYCLES 20'd600000

`endif

//--- ppc_cut_timer.v
// overload cut timer for one port
`timescale 1ns/1ps
`default_nettype none

module ppc_cut_timer #(
  parameter [19:0] CUT_CYCLES = 20'd600000
) (
  input wire clk,
  input wire rst,
  input wire powered,
  input wire [15:0] current,
  input wire [7:0] cut,
  output reg trip
);

  reg [19:0] cnt_reg;
  wire [15:0] limit_units;
  wire over;

  // one threshold step is 32 units of the 100 uA current scale
  assign limit_units = {3'h0, cut, 5'h00};
  // threshold is read live, so a host write takes effect at once
  assign over = current > limit_units;

  always @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 20'h00000;
      trip <= 1'b0;
    end else begin
      trip <= 1'b0;
      if (!powered || !over) begin
        cnt_reg <= 20'h00000;
      end else if (cnt_reg == CUT_CYCLES - 20'h00001) begin
        cnt_reg <= 20'h00000;
        trip <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 20'h00001;
      end
    end
  end

endmodule // ppc_cut_timer

`default_nettype wire

//--- ppc_port.v
// per-port mode, detection, classification and power sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.vh"

module ppc_port (
  input wire clk,
  input wire rst,
  input wire [1:0] mode,
  input wire disc_en,
  input wire det_good,
  input wire class_valid,
  input wire [2:0] class_result,
  input wire disconnect,
  input wire trip,
  input wire man_on,
  input wire man_off,
  input wire port_rst,
  output reg power,
  output wire det_en,
  output wire class_req,
  output wire mark_req,
  output reg class_err,
  output wire cut_load,
  output reg [2:0] class_first
);

  localparam [2:0] S_OFF = 3'h0;
  localparam [2:0] S_DET = 3'h1;
  localparam [2:0] S_CLS1 = 3'h2;
  localparam [2:0] S_MARK1 = 3'h3;
  localparam [2:0] S_CLS2 = 3'h4;
  localparam [2:0] S_MARK2 = 3'h5;
  localparam [2:0] S_HOLD = 3'h6;
  localparam [2:0] S_PWR = 3'h7;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg err_next;
  wire is_auto;
  wire is_manual;
  wire is_semi;
  wire drop;

  assign is_auto = mode == `PPC_MODE_AUTO;
  assign is_manual = mode == `PPC_MODE_MANUAL;
  assign is_semi = mode == `PPC_MODE_SEMIAUTO;
  // disconnect only removes power when enabled for the port
  assign drop = man_off | trip | (disconnect & disc_en);
  assign det_en = state_reg == S_DET;
  assign class_req = (state_reg == S_CLS1) || (state_reg == S_CLS2);
  assign mark_req = (state_reg == S_MARK1) || (state_reg == S_MARK2);
  // semiauto never loads the threshold, it keeps what the host wrote
  assign cut_load = is_auto && state_next == S_PWR && state_reg != S_PWR;

  always @* begin
    state_next = state_reg;
    err_next = class_err;
    if (mode == `PPC_MODE_SHUTDOWN || port_rst) begin
      state_next = S_OFF;
      err_next = 1'b0;
    end else begin
      case (state_reg)
        S_OFF: begin
          if (is_auto || is_semi) begin
            state_next = S_DET;
          end else if (man_on) begin
            state_next = S_CLS1;
          end
        end
        S_DET: begin
          if (is_manual) begin
            state_next = S_OFF;
          end else if (det_good) begin
            state_next = S_CLS1;
          end
        end
        S_CLS1: begin
          if (class_valid) begin
            err_next = 1'b0;
            if (class_result == `PPC_CLASS_OVL) begin
              err_next = 1'b1;
              state_next = S_HOLD;
            end else if (class_result == `PPC_CLASS_4 && !is_semi) begin
              state_next = S_MARK1;
            end else if (is_semi) begin
              state_next = S_HOLD;
            end else begin
              state_next = S_PWR;
            end
          end
        end
        S_MARK1: begin
          state_next = S_CLS2;
        end
        S_CLS2: begin
          if (class_valid) begin
            if (class_result == class_first) begin
              state_next = S_MARK2;
            end else begin
              err_next = 1'b1;
              state_next = S_HOLD;
            end
          end
        end
        S_MARK2: begin
          state_next = is_semi ? S_HOLD : S_PWR;
        end
        S_HOLD: begin
          if (is_auto && !det_good) begin
            state_next = S_DET;
          end else if (is_semi && man_on && !class_err) begin
            state_next = S_PWR;
          end else if (is_manual && man_on) begin
            state_next = S_CLS1;
          end
        end
        S_PWR: begin
          if (drop) begin
            state_next = S_OFF;
          end
        end
        default: begin
          state_next = S_OFF;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      state_reg <= S_OFF;
      class_err <= 1'b0;
      power <= 1'b0;
      class_first <= 3'h0;
    end else begin
      state_reg <= state_next;
      class_err <= err_next;
      power <= state_next == S_PWR;
      if (state_reg == S_CLS1 && class_valid) begin
        class_first <= class_result;
      end
    end
  end

endmodule // ppc_port

`default_nettype wire

//--- ppc_top_monitor.sv
// concurrent checks on the port controller top-level ports
`timescale 1ns/1ps
`default_nettype none

module ppc_top_monitor (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic OVERTEMP,
  input wire logic VEE_UVLO,
  input wire logic [3:0] PORT_POWER,
  input wire logic [3:0] MARK_REQ,
  input wire logic [3:0] CLASS_ERR,
  input wire logic [3:0] LIMIT_HIGH,
  input wire logic DET_BACKOFF,
  input wire logic INT_N
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // a status read only clears cleanly when no input edge lands on it
  wire st_rd = REG_RD && (REG_ADDR == 8'h1D) && !VEE_UVLO;
  wire cmd_wr = REG_WR && (REG_ADDR == 8'h12);

  a_reset_outputs: assert property ($fell(RST) |-> PORT_POWER == 4'h0 && INT_N)
    else $error("outputs not cleared by reset");
  a_limit_follow: assert property (REG_WR && REG_ADDR == 8'h0A && !VEE_UVLO
    && !$past(VEE_UVLO) |=> LIMIT_HIGH[0] == $past(REG_WDATA[3]))
    else $error("limit select off config");
  a_cmd_reads_zero: assert property (REG_RD && REG_ADDR == 8'h12 |=> REG_RDATA == 8'h00)
    else $error("command register read not zero");
  a_int_on_change: assert property ($changed(OVERTEMP) || $changed(VEE_UVLO) |=> !INT_N)
    else $error("status change raised no interrupt");
  a_read_clears_int: assert property (st_rd && $stable(OVERTEMP) && $stable(VEE_UVLO)
    |=> INT_N) else $error("status read left interrupt set");
  a_status_live: assert property (st_rd && $stable(OVERTEMP) && $stable(VEE_UVLO) |=>
    REG_RDATA[6] == $past(OVERTEMP) && REG_RDATA[0] == $past(DET_BACKOFF))
    else $error("status bits not live");
  a_backoff_toggle: assert property (cmd_wr && REG_WDATA == 8'h10 |=> ##1
    DET_BACKOFF != $past(DET_BACKOFF, 2)) else $error("back-off not toggled");
  a_mark_one_cycle: assert property (|MARK_REQ |=> (MARK_REQ & $past(MARK_REQ)) == 4'h0)
    else $error("mark longer than one cycle");
  a_refused_no_power: assert property ((CLASS_ERR & PORT_POWER & ~$past(PORT_POWER)) == 4'h0)
    else $error("refused port powered");

  c_mark: cover property (|MARK_REQ);
  c_refused: cover property (|CLASS_ERR);
  c_trip: cover property ($fell(PORT_POWER[1]));
  c_int: cover property ($fell(INT_N));
endmodule // ppc_top_monitor

bind ppc_top ppc_top_monitor u_ppc_top_monitor (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .OVERTEMP(OVERTEMP), .VEE_UVLO(VEE_UVLO), .PORT_POWER(PORT_POWER), .MARK_REQ(MARK_REQ),
  .CLASS_ERR(CLASS_ERR), .LIMIT_HIGH(LIMIT_HIGH), .DET_BACKOFF(DET_BACKOFF), .INT_N(INT_N));
`default_nettype wire

//--- ppc_pd_model.sv
// powered-device front end answering detection and classification requests
`timescale 1ns/1ps
`default_nettype none

module ppc_pd_model (
  input wire logic clk,
  input wire logic [3:0] det_en,
  input wire logic [3:0] class_req,
  input wire logic [3:0] sig_ok,
  input wire logic [11:0] cls,
  input wire logic [3:0] dly,
  output logic [3:0] det_good,
  output logic [3:0] class_valid,
  output logic [11:0] class_result
);
  logic [3:0] cnt [4];
  logic [3:0] done;
  logic hit;
  // result lines carry the inverse outside the strobe, so late sampling is caught
  always @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      hit = class_req[p] & ~done[p] & (cnt[p] == dly);
      det_good[p] <= det_en[p] & sig_ok[p];
      class_valid[p] <= hit;
      class_result[3*p +: 3] <= hit ? cls[3*p +: 3] : ~cls[3*p +: 3];
      done[p] <= class_req[p] & (done[p] | hit);
      cnt[p] <= (class_req[p] & ~done[p]) ? cnt[p] + 4'h1 : 4'h0;
    end
  end
endmodule // ppc_pd_model
`default_nettype wire

//--- tb_ppc_top.sv
// self-checking bench of the port controller register bank
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.vh"

module tb_ppc_top;
  localparam int CUT = 20;
  logic CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, OVERTEMP = 1'b0, VEE_UVLO = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  logic [15:0] VEE_MV = 16'hBB80;
  logic [63:0] PORT_CURRENT = 64'h0;
  logic [3:0] DISCONNECT = 4'h0, sig_ok = 4'h0, dly = 4'h2, DET_GOOD, CLASS_VALID;
  logic [11:0] cls = 12'h249, CLASS_RESULT;
  logic [3:0] PORT_POWER, DET_ENABLE, CLASS_REQ, MARK_REQ, CLASS_ERR, LIMIT_HIGH;
  logic DET_BACKOFF, INT_N;
  logic [7:0] ra [8] = '{8'h00, 8'h0A, 8'h0E, 8'h11, 8'h12, 8'h13, 8'h1D, 8'h30};
  logic [7:0] re [8] = '{8'h00, 8'h04, 8'h75, 8'h75, 8'h00, 8'h00, 8'h00, 8'h00};
  int n_errors = 0, n_checks = 0, w;

  always #50 CLK = ~CLK;
  ppc_top #(.CUT_CYCLES(20'd20)) u_ppc_top (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .OVERTEMP(OVERTEMP), .VEE_UVLO(VEE_UVLO), .VEE_MV(VEE_MV), .PORT_CURRENT(PORT_CURRENT),
    .DET_GOOD(DET_GOOD), .CLASS_VALID(CLASS_VALID), .CLASS_RESULT(CLASS_RESULT),
    .DISCONNECT(DISCONNECT), .PORT_POWER(PORT_POWER), .DET_ENABLE(DET_ENABLE),
    .CLASS_REQ(CLASS_REQ), .MARK_REQ(MARK_REQ), .CLASS_ERR(CLASS_ERR),
    .LIMIT_HIGH(LIMIT_HIGH), .DET_BACKOFF(DET_BACKOFF), .INT_N(INT_N));
  ppc_pd_model u_ppc_pd_model (.clk(CLK), .det_en(DET_ENABLE), .class_req(CLASS_REQ),
    .sig_ok(sig_ok), .cls(cls), .dly(dly), .det_good(DET_GOOD), .class_valid(CLASS_VALID),
    .class_result(CLASS_RESULT));

  task close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task ck(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // one idle cycle before each strobe keeps every strobe a single-cycle pulse
  task wr(input logic [7:0] a, input logic [7:0] d);
    idle(1);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    idle(1);
    REG_WR = 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    idle(1);
    REG_RD = 1'b1;
    REG_ADDR = a;
    idle(1);
    REG_RD = 1'b0;
    ck($sformatf("reg %h", a), {8'h00, e}, {8'h00, REG_RDATA});
  endtask
  task cmd(input logic [2:0] c, input logic [1:0] p);
    wr(`PPC_OFS_CMD, {3'h0, c, p});
  endtask
  task wp(input int p, input logic v);
    int i;
    for (i = 0; i < 60 && PORT_POWER[p] !== v; i++) idle(1);
    ck($sformatf("power %0d", p), {15'h0, v}, {15'h0, PORT_POWER[p]});
    if (i == 60) close_out;
  endtask

  initial begin
    idle(8);
    RST = 1'b0;
    wr(8'h13, 8'hFF);
    wr(`PPC_OFS_STAT, 8'hFF);
    foreach (ra[i]) rc(ra[i], re[i]);
    for (int p = 0; p < 4; p++) begin
      wr(8'(8'h0A + p), 8'hF8);
      rc(8'(8'h0A + p), 8'h08);
    end
    ck("limit", 16'h000F, {12'h000, LIMIT_HIGH});
    wr(`PPC_OFS_CFG, 8'h00);
    ck("limit", 16'h000E, {12'h000, LIMIT_HIGH});
    cmd(`PPC_CMD_PORT_ON, 2'h0);
    idle(10);
    ck("shutdown", 16'h0, {13'h0, PORT_POWER[0], DET_ENABLE[0], CLASS_REQ[0]});
    $display("test reset and config done");
    wr(`PPC_OFS_CFG, 8'h05);
    idle(10);
    ck("manual idle", 16'h0, {15'h0, PORT_POWER[0]});
    cmd(`PPC_CMD_PORT_ON, 2'h0);
    wp(0, 1'b1);
    PORT_CURRENT[15:0] = 16'h1234;
    cmd(`PPC_CMD_MEAS_CURRENT, 2'h0);
    rc(8'h13, 8'h34);
    rc(8'h14, 8'h12);
    PORT_CURRENT[15:0] = 16'h0EA0;
    wr(`PPC_OFS_CFG, 8'h01);
    DISCONNECT[0] = 1'b1;
    idle(5);
    ck("disc off", 16'h1, {15'h0, PORT_POWER[0]});
    wr(`PPC_OFS_CFG, 8'h05);
    wp(0, 1'b0);
    DISCONNECT[0] = 1'b0;
    rc(8'h13, 8'h34);
    cmd(`PPC_CMD_MEAS_CURRENT, 2'h0);
    rc(8'h13, 8'h00);
    cls[2:0] = `PPC_CLASS_OVL;
    cmd(`PPC_CMD_PORT_ON, 2'h0);
    idle(20);
    ck("ovl class", 16'h2, {14'h0, CLASS_ERR[0], PORT_POWER[0]});
    $display("test manual done");
    cls[5:3] = `PPC_CLASS_4;
    sig_ok[1] = 1'b1;
    dly = 4'h5;
    wr(8'h0B, 8'h0B);
    wp(1, 1'b1);
    rc(8'h0F, `PPC_CUT_HIGH);
    sig_ok[1] = 1'b0;
    wr(8'h0F, 8'h10);
    PORT_CURRENT[31:16] = 16'd512;
    idle(3 * CUT);
    ck("cut equal", 16'h1, {15'h0, PORT_POWER[1]});
    PORT_CURRENT[31:16] = 16'd513;
    idle(CUT - 4);
    ck("cut early", 16'h1, {15'h0, PORT_POWER[1]});
    wp(1, 1'b0);
    cls[8:6] = `PPC_CLASS_4;
    sig_ok[2] = 1'b1;
    dly = 4'h0;
    wr(8'h0C, 8'h07);
    for (w = 0; w < 60 && CLASS_VALID[2] !== 1'b1; w++) idle(1);
    ck("class strobe", 16'h1, {15'h0, CLASS_VALID[2]});
    if (w == 60) close_out;
    cls[8:6] = 3'h1;
    sig_ok[2] = 1'b0;
    idle(30);
    ck("two event", 16'h2, {14'h0, CLASS_ERR[2], PORT_POWER[2]});
    sig_ok[3] = 1'b1;
    wr(8'h0D, 8'h06);
    idle(30);
    ck("semiauto", 16'h0, {15'h0, PORT_POWER[3]});
    rc(8'h11, `PPC_CUT_RESET);
    cmd(`PPC_CMD_PORT_ON, 2'h3);
    wp(3, 1'b1);
    cmd(`PPC_CMD_PORT_OFF, 2'h3);
    wp(3, 1'b0);
    idle(10);
    cmd(`PPC_CMD_PORT_ON, 2'h3);
    wp(3, 1'b1);
    cmd(`PPC_CMD_PORT_RESET, 2'h3);
    wp(3, 1'b0);
    $display("test automatic modes done");
    cmd(`PPC_CMD_MEAS_VEE, 2'h0);
    rc(8'h1B, 8'h80);
    rc(8'h1C, 8'hBB);
    for (int k = 1; k >= 0; k--) begin
      wr(`PPC_OFS_CMD, 8'h10);
      idle(2);
      ck("backoff", 16'(k), {15'h0, DET_BACKOFF});
      rc(`PPC_OFS_STAT, 8'(k));
    end
    OVERTEMP = 1'b1;
    idle(2);
    ck("int pin", 16'h0, {15'h0, INT_N});
    rc(`PPC_OFS_INT, 8'h40);
    rc(`PPC_OFS_STAT, 8'h40);
    ck("int pin", 16'h1, {15'h0, INT_N});
    rc(`PPC_OFS_STAT, 8'h40);
    OVERTEMP = 1'b0;
    idle(2);
    rc(`PPC_OFS_INT, 8'h40);
    rc(`PPC_OFS_STAT, 8'h00);
    cls[2:0] = 3'h1;
    cmd(`PPC_CMD_PORT_ON, 2'h0);
    wp(0, 1'b1);
    VEE_UVLO = 1'b1;
    wp(0, 1'b0);
    rc(`PPC_OFS_INT, 8'h20);
    rc(`PPC_OFS_STAT, 8'h20);
    rc(`PPC_OFS_CFG, `PPC_CFG_RESET);
    VEE_UVLO = 1'b0;
    idle(2);
    rc(`PPC_OFS_STAT, 8'h00);
    wr(8'h0B, 8'h08);
    wr(8'h0F, 8'h10);
    cmd(`PPC_CMD_CHIP_RESET, 2'h0);
    idle(2);
    rc(8'h0B, `PPC_CFG_RESET);
    rc(8'h0F, `PPC_CUT_RESET);
    $display("test global done");
    close_out;
  end
endmodule // tb_ppc_top
`default_nettype wire
